/* File: boot_ctrl_params.svh */
// Constants for boot source selection and reset control
// Operation
// - Boot source chosen from three-pin strap
// - Floating strap pin is a third state
// - F00 sync muxed, F01 async muxed
// - F11 USB boot, F0F async SRAM
// - F1F/0F1 fall back to USB; 1FF none
// - SPI flash of 4/8/16/32 Mbit only
// - I2C boot as master from EEPROM
// - Low hard reset pin restarts device
// - All I/O high impedance during hard reset
// - Bootloader configures I/O per strap after reset
// - Soft reset: CPU reset or device reset
// - CPU reset clears PC, keeps firmware
// - Device reset acts as hard reset
// - Deepest low-power exit loses firmware
`ifndef BOOT_CTRL_PARAMS_SVH
`define BOOT_CTRL_PARAMS_SVH

`define CLK_MHZ         200
`define SETTLE_NS       100
`define CPU_RST_NS      80
`define DEV_RST_NS      200
`define SETTLE_CYC      ((`SETTLE_NS * `CLK_MHZ + 999) / 1000)
`define CPU_RST_CYC     ((`CPU_RST_NS * `CLK_MHZ + 999) / 1000)
`define DEV_RST_CYC     ((`DEV_RST_NS * `CLK_MHZ + 999) / 1000)

`define STRAP_F00       6'h20
`define STRAP_F01       6'h21
`define STRAP_F11       6'h25
`define STRAP_F0F       6'h22
`define STRAP_F1F       6'h26
`define STRAP_1FF       6'h1a
`define STRAP_0F1       6'h09
`define STRAP_RST       6'h00

`define SPI_MBIT_4      8'h04
`define SPI_MBIT_8      8'h08
`define SPI_MBIT_16     8'h10
`define SPI_MBIT_32     8'h20

`endif

/* File: boot_ctrl_pkg.sv */
// Types for boot source selection and reset control
package boot_ctrl_pkg;

  typedef enum logic [1:0] {
    LVL_LO = 2'b00,
    LVL_HI = 2'b01,
    LVL_FL = 2'b10
  } pin_level_t;

  typedef enum logic [2:0] {
    SRC_NONE       = 3'b000,
    SRC_SYNC_ADDRESS_DATA_MUXED_MODE = 3'b001,
    SRC_ASYN_ADDRESS_DATA_MUXED_MODE = 3'b010,
    SRC_ASYN_SRAM  = 3'b011,
    SRC_USB        = 3'b100,
    SRC_I2C        = 3'b101,
    SRC_SPI        = 3'b110
  } boot_src_t;

  typedef enum logic [2:0] {
    ST_HOLD    = 3'b000,
    ST_PULL_UP = 3'b001,
    ST_PULL_DN = 3'b010,
    ST_DECODE  = 3'b011,
    ST_LOAD    = 3'b100,
    ST_RUN     = 3'b101,
    ST_CPU_RST = 3'b110,
    ST_HALT    = 3'b111
  } fsm_t;

  typedef struct packed {
    boot_src_t src;
    logic      usb_fallback;
    logic      reserved;
    logic      fw_valid;
  } boot_status_t;

endpackage : boot_ctrl_pkg

/* File: boot_source_and_reset_control.sv */
// Strap decode, bootloader sequencing and reset control
`timescale 1ns/1ps
`include "boot_ctrl_params.svh"

module boot_source_and_reset_control
  import boot_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  // Device pins and supply
  input  wire logic         i_hard_reset_n,
  input  wire logic         i_core_power_good,
  input  wire logic [2:0]   i_boot_select_strap,
  // Soft reset requests from processor_port_init_control
  input  wire logic         i_cpu_reset_req,
  input  wire logic         i_device_reset_req,
  // Bootloader handshake
  input  wire logic         i_load_done,
  input  wire logic         i_load_fail,
  input  wire logic [7:0]   i_spi_mbit,
  // Pad and core control
  output logic              o_io_hiz,
  output logic              o_strap_pull_up,
  output logic              o_core_reset,
  output logic              o_cpu_pc_reset,
  // Boot control
  output logic              o_loader_start,
  output logic              o_loader_active,
  output logic              o_i2c_master_en,
  output boot_status_t      o_boot_status
);

  typedef struct packed {
    fsm_t         st;
    logic [1:0]   rst_s1;
    logic [1:0]   rst_s2;
    logic [2:0]   pin_s1;
    logic [2:0]   pin_s2;
    logic [2:0]   up_smp;
    logic [5:0]   code;
    logic [7:0]   cnt;
    logic         start;
    boot_status_t stat;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic       pins_ok;
  logic       spi_ok;
  logic       load_bad;
  logic [5:0] code_nxt;

  // Reset pin and supply both synchronised; low on either restarts all
  assign pins_ok = st_r.rst_s2[1] & st_r.rst_s2[0];

  always_comb begin
    case (i_spi_mbit)
      `SPI_MBIT_4, `SPI_MBIT_8,
      `SPI_MBIT_16, `SPI_MBIT_32: spi_ok = 1'b1;
      default:                    spi_ok = 1'b0;
    endcase
  end

  assign load_bad = i_load_fail |
                    ((st_r.stat.src == SRC_SPI) & ~spi_ok);

  // Pull-up gives 1 and pull-down 0 only on a floating pin
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_lvl
      assign code_nxt[2*g +: 2] =
        (st_r.up_smp[g] != st_r.pin_s2[g]) ? LVL_FL :
        (st_r.pin_s2[g] ? LVL_HI : LVL_LO);
    end
  endgenerate

  always_comb begin
    st_nxt        = st_r;
    st_nxt.rst_s1 = {i_hard_reset_n, i_core_power_good};
    st_nxt.rst_s2 = st_r.rst_s1;
    st_nxt.pin_s1 = i_boot_select_strap;
    st_nxt.pin_s2 = st_r.pin_s1;
    st_nxt.start  = 1'b0;
    st_nxt.cnt    = st_r.cnt + 8'h01;
    case (st_r.st)
      ST_HOLD: begin
        if (st_r.cnt == 8'(`DEV_RST_CYC - 1)) begin
          st_nxt.st  = ST_PULL_UP;
          st_nxt.cnt = 8'h00;
        end
      end
      ST_PULL_UP: begin
        if (st_r.cnt == 8'(`SETTLE_CYC - 1)) begin
          st_nxt.up_smp = st_r.pin_s2;
          st_nxt.st     = ST_PULL_DN;
          st_nxt.cnt    = 8'h00;
        end
      end
      ST_PULL_DN: begin
        if (st_r.cnt == 8'(`SETTLE_CYC - 1)) begin
          st_nxt.code = code_nxt;
          st_nxt.st   = ST_DECODE;
        end
      end
      ST_DECODE: begin
        st_nxt.st    = ST_LOAD;
        st_nxt.start = 1'b1;
        case (st_r.code)
          `STRAP_F00: st_nxt.stat.src = SRC_SYNC_ADDRESS_DATA_MUXED_MODE;
          `STRAP_F01: st_nxt.stat.src = SRC_ASYN_ADDRESS_DATA_MUXED_MODE;
          `STRAP_F11: st_nxt.stat.src = SRC_USB;
          `STRAP_F0F: st_nxt.stat.src = SRC_ASYN_SRAM;
          `STRAP_F1F: begin
            st_nxt.stat.src          = SRC_I2C;
            st_nxt.stat.usb_fallback = 1'b1;
          end
          `STRAP_1FF: st_nxt.stat.src = SRC_I2C;
          `STRAP_0F1: begin
            st_nxt.stat.src          = SRC_SPI;
            st_nxt.stat.usb_fallback = 1'b1;
          end
          default: begin
            st_nxt.stat.reserved = 1'b1;
            st_nxt.st            = ST_HALT;
            st_nxt.start         = 1'b0;
          end
        endcase
      end
      ST_LOAD: begin
        if (load_bad) begin
          // Fallback restarts the loader once on USB
          if (st_r.stat.usb_fallback) begin
            st_nxt.stat.src          = SRC_USB;
            st_nxt.stat.usb_fallback = 1'b0;
            st_nxt.start             = 1'b1;
          end else begin
            st_nxt.st = ST_HALT;
          end
        end else if (i_load_done) begin
          st_nxt.stat.fw_valid = 1'b1;
          st_nxt.st            = ST_RUN;
        end
      end
      ST_RUN: begin
        if (i_device_reset_req) begin
          st_nxt = '0;
          st_nxt.rst_s1 = {i_hard_reset_n, i_core_power_good};
          st_nxt.rst_s2 = st_r.rst_s1;
          st_nxt.pin_s1 = i_boot_select_strap;
          st_nxt.pin_s2 = st_r.pin_s1;
        end else if (i_cpu_reset_req) begin
          st_nxt.st  = ST_CPU_RST;
          st_nxt.cnt = 8'h00;
        end
      end
      ST_CPU_RST: begin
        if (st_r.cnt == 8'(`CPU_RST_CYC - 1)) begin
          st_nxt.st = ST_RUN;
        end
      end
      ST_HALT: begin
        st_nxt.st = ST_HALT;
      end
      default: begin
        st_nxt.st = ST_HOLD;
      end
    endcase
    // Pin or supply loss wins over everything; RAM contents gone
    if (!pins_ok) begin
      st_nxt.st   = ST_HOLD;
      st_nxt.cnt  = 8'h00;
      st_nxt.stat = '0;
      st_nxt.code = `STRAP_RST;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Pads stay released until the strap is read
  assign o_io_hiz        = (st_r.st == ST_HOLD) ||
                           (st_r.st == ST_PULL_UP) ||
                           (st_r.st == ST_PULL_DN);
  assign o_strap_pull_up = (st_r.st == ST_PULL_UP);
  assign o_core_reset    = (st_r.st == ST_HOLD);
  assign o_cpu_pc_reset  = (st_r.st != ST_RUN);
  assign o_loader_start  = st_r.start;
  assign o_loader_active = (st_r.st == ST_LOAD);
  assign o_i2c_master_en = (st_r.st == ST_LOAD) &&
                           (st_r.stat.src == SRC_I2C);
  assign o_boot_status   = st_r.stat;

  sequence s_cpu_req;
    (st_r.st == ST_RUN) && i_cpu_reset_req && !i_device_reset_req &&
    pins_ok;
  endsequence

  sequence s_cpu_pulse;
    (o_cpu_pc_reset && st_r.stat.fw_valid)[*8];
  endsequence

  sequence s_pull_start;
    $rose(st_r.st == ST_PULL_UP);
  endsequence

  a_hiz_in_reset: assert property (@(posedge i_clk) disable iff (i_srst)
    !pins_ok |=> o_io_hiz && o_core_reset)
    else $error("Pads not released during hard reset");

  a_strap_settle: assert property (@(posedge i_clk) disable iff (i_srst)
    s_pull_start |-> (o_strap_pull_up || !pins_ok)[*8])
    else $error("Strap pull-up phase too short");

  a_float_decode: assert property (@(posedge i_clk) disable iff (i_srst)
    (st_r.st == ST_PULL_DN) && pins_ok &&
    (st_r.cnt == 8'(`SETTLE_CYC - 1)) &&
    (st_r.up_smp[0] != st_r.pin_s2[0]) |=> st_r.code[1:0] == LVL_FL)
    else $error("Floating strap pin not decoded");

  a_code_sync_mux: assert property (@(posedge i_clk) disable iff (i_srst)
    (st_r.st == ST_DECODE) && pins_ok && (st_r.code == `STRAP_F00)
    |=> (st_r.stat.src == SRC_SYNC_ADDRESS_DATA_MUXED_MODE) && o_loader_start)
    else $error("Strap F00 not decoded");

  a_code_usb: assert property (@(posedge i_clk) disable iff (i_srst)
    (st_r.st == ST_DECODE) && pins_ok && (st_r.code == `STRAP_F11)
    |=> (st_r.stat.src == SRC_USB) && !st_r.stat.usb_fallback)
    else $error("Strap F11 not decoded");

  a_fallback_usb: assert property (@(posedge i_clk) disable iff (i_srst)
    (st_r.st == ST_LOAD) && pins_ok && i_load_fail &&
    st_r.stat.usb_fallback
    |=> (st_r.stat.src == SRC_USB) && o_loader_start ##1 !o_loader_start)
    else $error("Fallback to USB boot missing");

  a_spi_reject: assert property (@(posedge i_clk) disable iff (i_srst)
    (st_r.st == ST_LOAD) && pins_ok && (st_r.stat.src == SRC_SPI) &&
    !spi_ok |=> (st_r.stat.src == SRC_USB) && o_loader_start)
    else $error("Unsupported SPI flash accepted");

  a_i2c_master: assert property (@(posedge i_clk) disable iff (i_srst)
    o_i2c_master_en |-> o_loader_active && !o_io_hiz)
    else $error("I2C master outside loading");

  a_loader_after: assert property (@(posedge i_clk) disable iff (i_srst)
    $rose(o_loader_active) |-> $past(st_r.st == ST_DECODE) &&
    (st_r.stat.src != SRC_NONE))
    else $error("Loader started without decode");

  a_cpu_keep_fw: assert property (@(posedge i_clk) disable iff (i_srst)
    s_cpu_req |=> s_cpu_pulse)
    else $error("CPU reset lost firmware or too short");

  a_dev_reset: assert property (@(posedge i_clk) disable iff (i_srst)
    (st_r.st == ST_RUN) && i_device_reset_req
    |=> o_core_reset && !st_r.stat.fw_valid && o_io_hiz)
    else $error("Device reset not like hard reset");

  a_power_loss: assert property (@(posedge i_clk) disable iff (i_srst)
    !st_r.rst_s2[0] |=> !st_r.stat.fw_valid && o_core_reset)
    else $error("Firmware kept across power loss");

  a_strap_frozen: assert property (@(posedge i_clk) disable iff (i_srst)
    (st_r.st == ST_RUN) && $past(st_r.st == ST_RUN)
    |-> $stable(st_r.code) && $stable(st_r.stat.src))
    else $error("Boot source changed while running");

  a_reserved_halt: assert property (@(posedge i_clk) disable iff (i_srst)
    (st_r.st == ST_DECODE) && pins_ok && (st_r.code == 6'h00)
    |=> (st_r.st == ST_HALT) && st_r.stat.reserved && !o_loader_start)
    else $error("Reserved strap code not halted");

  sequence s_load_ok;
    (st_r.st == ST_LOAD) && pins_ok && i_load_done && !load_bad;
  endsequence

  a_load_done: assert property (@(posedge i_clk) disable iff (i_srst)
    s_load_ok |=> (st_r.st == ST_RUN) && st_r.stat.fw_valid)
    else $error("Successful load did not start firmware");

  a_cpu_return: assert property (@(posedge i_clk) disable iff (i_srst)
    (st_r.st == ST_CPU_RST) && pins_ok &&
    (st_r.cnt == 8'(`CPU_RST_CYC - 1))
    |=> !o_cpu_pc_reset && st_r.stat.fw_valid)
    else $error("CPU reset did not release");

  a_hold_exit: assert property (@(posedge i_clk) disable iff (i_srst)
    (st_r.st == ST_HOLD) && pins_ok &&
    (st_r.cnt == 8'(`DEV_RST_CYC - 1))
    |=> o_strap_pull_up && o_io_hiz && !o_core_reset)
    else $error("Restart did not move to strap read");

  a_code_frozen: assert property (@(posedge i_clk) disable iff (i_srst)
    (st_r.st == ST_LOAD) && $past(st_r.st == ST_LOAD)
    |-> $stable(st_r.code))
    else $error("Strap code changed while loading");

  a_halt_stays: assert property (@(posedge i_clk) disable iff (i_srst)
    (st_r.st == ST_HALT) && pins_ok
    |=> (st_r.st == ST_HALT) && !o_loader_active)
    else $error("Halted loader woke up");

endmodule : boot_source_and_reset_control

/* File: boot_partner_model.sv */
// Far-side model: strap pads and boot image sources
`timescale 1ns/1ps

module boot_partner_model
  import boot_ctrl_pkg::*;
(
  // Clock
  input  wire logic       i_clk,
  // Scenario controls
  input  wire logic [5:0] i_code,
  input  wire logic       i_fail,
  input  wire logic       i_slow,
  // From the device
  input  wire logic       i_pull_up,
  input  wire logic       i_start,
  input  wire boot_src_t  i_src,
  // To the device
  output logic [2:0]      o_strap,
  output logic            o_done,
  output logic            o_fail
);
  int cnt = -1;

  // Floating pad follows the weak pull, never a stale level
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      o_strap[k] = i_code[2*k+1] ? i_pull_up : i_code[2*k];
    end
  end

  // One answer per load attempt; USB host never refuses
  always @(posedge i_clk) begin
    #1;
    {o_done, o_fail} = 2'b00;
    if (cnt == 0) begin
      if (i_fail && i_src != SRC_USB) begin
        o_fail = 1'b1;
      end else begin
        o_done = 1'b1;
      end
    end
    cnt = (i_start === 1'b1) ? (i_slow ? 10 : 2) : cnt - 1;
  end
endmodule : boot_partner_model

/* File: boot_source_and_reset_control_tb.sv */
// Self-checking bench for boot source selection and reset control
`timescale 1ns/1ps

module boot_source_and_reset_control_tb;
  import boot_ctrl_pkg::*;
  logic         clk = 1'b0;
  logic         srst = 1'b1;
  logic         hard_n = 1'b1;
  logic         pgood = 1'b1;
  logic         cpu_req = 1'b0;
  logic         dev_req = 1'b0;
  logic [7:0]   mbit = 8'h04;
  logic [5:0]   code = 6'h20;
  logic         fail = 1'b0;
  logic         slow = 1'b0;
  logic [2:0]   strap;
  logic         done;
  logic         lfail;
  logic         hiz;
  logic         pull_up;
  logic         core_rst;
  logic         pc_rst;
  logic         start;
  logic         active;
  logic         i2c_en;
  boot_status_t st;
  int           n_errors = 0;
  int           num_checks = 0;
  logic [5:0]   codes[7] = '{6'h20, 6'h21, 6'h25, 6'h22, 6'h26, 6'h1a, 6'h09};
  boot_src_t    srcs[7] = '{SRC_SYNC_ADDRESS_DATA_MUXED_MODE, SRC_ASYN_ADDRESS_DATA_MUXED_MODE, SRC_USB,
    SRC_ASYN_SRAM, SRC_I2C, SRC_I2C, SRC_SPI};
  logic         fbs[7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  logic [7:0]   sizes[4] = '{8'h04, 8'h08, 8'h10, 8'h20};

  always #2.5 clk = ~clk;

  boot_source_and_reset_control dut_u (
    .i_clk(clk), .i_srst(srst), .i_hard_reset_n(hard_n),
    .i_core_power_good(pgood), .i_boot_select_strap(strap),
    .i_cpu_reset_req(cpu_req), .i_device_reset_req(dev_req),
    .i_load_done(done), .i_load_fail(lfail), .i_spi_mbit(mbit),
    .o_io_hiz(hiz), .o_strap_pull_up(pull_up), .o_core_reset(core_rst),
    .o_cpu_pc_reset(pc_rst), .o_loader_start(start),
    .o_loader_active(active), .o_i2c_master_en(i2c_en),
    .o_boot_status(st));

  boot_partner_model partner_u (
    .i_clk(clk), .i_code(code), .i_fail(fail), .i_slow(slow),
    .i_pull_up(pull_up), .i_start(start), .i_src(st.src),
    .o_strap(strap), .o_done(done), .o_fail(lfail));

  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wait_start();
    int n;
    n = 0;
    while (start !== 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
    chk(n < 300, "no load start");
  endtask : wait_start

  task automatic boot(input logic [5:0] c, input boot_src_t s,
                      input logic fb, input logic f);
    code = c;
    fail = f;
    srst = 1'b1;
    cyc(2);
    srst = 1'b0;
    wait_start();
    chk(st.src === s && st.usb_fallback === fb, "boot source");
    chk(hiz === 1'b0 && active === 1'b1, "pads after boot");
    chk(i2c_en === (s == SRC_I2C), "i2c master enable");
    if (f || (s == SRC_SPI && !(mbit inside {sizes}))) begin
      cyc(1);
      wait_start();
      chk(st.src === SRC_USB && st.usb_fallback === 1'b0, "fallback");
    end
    cyc(14);
    chk(st.fw_valid === 1'b1 && pc_rst === 1'b0, "not running");
  endtask : boot

  task automatic halt_case(input logic [5:0] c);
    int starts;
    int ups;
    code = c;
    fail = 1'b1;
    starts = 0;
    ups = 0;
    srst = 1'b1;
    cyc(2);
    srst = 1'b0;
    repeat (150) begin
      cyc(1);
      if (start === 1'b1) starts++;
      if (pull_up === 1'b1) ups++;
    end
    chk(starts == ((c == 6'h00) ? 0 : 1), "start count");
    chk(ups == 20, "pull-up phase length");
    chk(active === 1'b0 && st.fw_valid === 1'b0, "halt");
    chk(st.reserved === (c == 6'h00), "reserved flag");
  endtask : halt_case

  task automatic hard_case(input logic pin);
    boot(6'h25, SRC_USB, 1'b0, 1'b0);
    if (pin) hard_n = 1'b0;
    else pgood = 1'b0;
    cyc(4);
    chk(hiz === 1'b1 && core_rst === 1'b1 && pull_up === 1'b0,
        "pads in reset");
    cyc(6);
    chk(hiz === 1'b1 && st.fw_valid === 1'b0, "firmware kept");
    hard_n = 1'b1;
    pgood = 1'b1;
    wait_start();
    chk(st.src === SRC_USB, "reboot source");
  endtask : hard_case

  task automatic soft_case();
    int bad;
    boot(6'h09, SRC_SPI, 1'b1, 1'b0);
    code = 6'h00;
    cyc(4);
    chk(st.src === SRC_SPI && st.reserved === 1'b0, "strap resampled");
    cpu_req = 1'b1;
    cyc(1);
    cpu_req = 1'b0;
    bad = 0;
    for (int i = 0; i < 17; i++) begin
      if (pc_rst !== (i < 16)) bad++;
      cyc(1);
    end
    chk(bad == 0 && st.fw_valid === 1'b1, "cpu reset");
    dev_req = 1'b1;
    cyc(1);
    dev_req = 1'b0;
    cyc(1);
    chk(hiz === 1'b1 && st.fw_valid === 1'b0, "device reset");
    cyc(150);
    chk(st.reserved === 1'b1 && active === 1'b0, "strap reread");
  endtask : soft_case

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  // Whole run is near 11 us; a hang is cut well past that
  initial begin
    #100000;
    n_errors++;
    summarize();
  end

  initial begin
    cyc(12);
    srst = 1'b0;
    for (int i = 0; i < 7; i++) begin
      slow = i[0];
      boot(codes[i], srcs[i], fbs[i], 1'b0);
    end
    boot(6'h26, SRC_I2C, 1'b1, 1'b1);
    halt_case(6'h1a);
    halt_case(6'h00);
    for (int i = 0; i < 4; i++) begin
      mbit = sizes[i];
      boot(6'h09, SRC_SPI, 1'b1, 1'b0);
    end
    mbit = 8'h05;
    boot(6'h09, SRC_SPI, 1'b1, 1'b0);
    mbit = 8'h04;
    hard_case(1'b1);
    hard_case(1'b0);
    soft_case();
    summarize();
  end
endmodule : boot_source_and_reset_control_tb
